// ### logic/link_b_lanes_and_overrange_cfg.sv
/*
  Second-link extra-lane enables, sync word select and over-range detection
  with pin gating, behind an Avalon-MM slave with waitrequest.
  Assumes all inputs come from logic on sys_clk (the device clock).
*/
// The Avalon-MM register port was decided locally.
`include "ovr_defines.svh"

module link_b_lanes_and_overrange_cfg (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   clk_en,
  input  wire ovr_pkg::avs_req_t      avs_req,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   link_enable,
  input  wire logic [7:0]             mode_lane_mask,
  input  wire logic                   mode_is_64b66b,
  input  wire logic [3:0]             link_test_pattern_select,
  input  wire logic [1:0]             channel_power_down,
  input  wire logic [7:0]             chan_a_sample,
  input  wire logic [7:0]             chan_b_sample,
  output logic [7:0]                  lane_clk_en,
  output logic [7:0]                  lane_ser_en,
  output ovr_pkg::lane_pattern_t      lane_pattern,
  output logic                        sync_word_fec,
  output logic [6:0]                  link_cmd_field,
  output logic [3:0]                  ovr_stream,
  output logic                        chan_a_overrange_out_zero,
  output logic                        chan_a_overrange_out_one,
  output logic                        chan_b_overrange_out_zero,
  output logic                        chan_b_overrange_out_one,
  output logic                        irq
);
  import ovr_pkg::*;

  bus_state_t    state_reg;
  bus_state_t    state_next;
  logic          wait_reg;
  logic          wait_next;
  logic [31:0]   rdata_reg;
  logic [31:0]   rdata_next;
  logic          wr_fire;
  logic [9:0]    idx;
  logic [7:0]    read_mux;
  logic [7:0]    extra_lane_reg;
  logic [7:0]    extra_lane_next;
  logic [7:0]    sync_word_content_reg;
  logic [7:0]    sync_word_content_next;
  logic [7:0]    level_zero_reg;
  logic [7:0]    level_zero_next;
  logic [7:0]    level_one_reg;
  logic [7:0]    level_one_next;
  logic [7:0]    overrange_output_config_reg;
  logic [7:0]    overrange_output_config_next;
  logic [4:0]    status_reg;
  logic [4:0]    status_next;
  logic [4:0]    mask_reg;
  logic [4:0]    mask_next;
  logic [4:0]    events;
  logic [3:0]    flag_prev_reg;
  logic          irq_reg;
  logic          irq_next;
  logic [7:0]    clk_en_reg;
  logic [7:0]    clk_en_next;
  logic [7:0]    ser_en_reg;
  logic [7:0]    ser_en_next;
  lane_pattern_t pattern_reg;
  lane_pattern_t pattern_next;
  logic          fec_reg;
  logic          fec_next;
  logic [3:0]    pins_reg;
  logic [3:0]    pins_next;
  logic [3:0]    hits;
  logic [3:0]    flags;
  logic [8:0]    level_a;
  logic [8:0]    level_b;
  logic [7:0]    extra_mask;
  logic          powered;
  logic          overrange_pin_enable;
  logic [2:0]    overrange_pulse_stretch;

  assign idx                     = avs_req.address[11:2];
  assign overrange_pin_enable    = overrange_output_config_reg[`OVERRANGE_PIN_ENABLE_BIT];
  assign overrange_pulse_stretch = overrange_output_config_reg[`STRETCH_HI:`STRETCH_LO];

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: waitrequest low for one cycle per request
  always_comb
  begin
    case (idx)
      `IDX_EXTRA_LANE: read_mux = extra_lane_reg;
      `IDX_SYNC_WORD:  read_mux = sync_word_content_reg;
      `IDX_LEVEL_ZERO: read_mux = level_zero_reg;
      `IDX_LEVEL_ONE:  read_mux = level_one_reg;
      `IDX_OVERRANGE_OUTPUT_CONFIG:    read_mux = overrange_output_config_reg;
      `IDX_IRQ_STATUS: read_mux = {3'h0, status_reg};
      `IDX_IRQ_MASK:   read_mux = {3'h0, mask_reg};
      `IDX_OVR_STATE:  read_mux = {4'h0, flags};
      default:         read_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    rdata_next = rdata_reg;
    wr_fire    = 1'b0;
    case (state_reg)
      BUS_IDLE:
      begin
        if (avs_req.read || avs_req.write)
        begin
          state_next = BUS_ACK;
          rdata_next = avs_req.read ? {24'h0, read_mux} : 32'h0;
        end
      end
      BUS_ACK:
      begin
        state_next = BUS_IDLE;
        wr_fire    = avs_req.write;
      end
      default: state_next = BUS_IDLE;
    endcase
    wait_next = (state_next != BUS_ACK);
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= BUS_IDLE;
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register file and interrupt status
  always_comb
  begin
    extra_lane_next        = extra_lane_reg;
    sync_word_content_next = sync_word_content_reg;
    level_zero_next        = level_zero_reg;
    level_one_next         = level_one_reg;
    overrange_output_config_next           = overrange_output_config_reg;
    mask_next              = mask_reg;
    events[3:0]            = flags & ~flag_prev_reg;
    events[4]              = 1'b0;
    status_next            = status_reg;
    if (wr_fire)
    begin
      case (idx)
        `IDX_EXTRA_LANE:
        begin
          extra_lane_next = avs_req.writedata[7:0];
          events[4]       = link_enable;
        end
        `IDX_SYNC_WORD:
        begin
          sync_word_content_next = avs_req.writedata[7:0];
          events[4]              = link_enable;
        end
        `IDX_LEVEL_ZERO: level_zero_next = avs_req.writedata[7:0];
        `IDX_LEVEL_ONE:  level_one_next = avs_req.writedata[7:0];
        `IDX_OVERRANGE_OUTPUT_CONFIG:    overrange_output_config_next = avs_req.writedata[7:0];
        `IDX_IRQ_STATUS: status_next = status_reg & ~avs_req.writedata[4:0];
        `IDX_IRQ_MASK:   mask_next = avs_req.writedata[4:0];
        default:         mask_next = mask_reg;
      endcase
    end
    status_next = status_next | events;
    irq_next    = |(status_next & mask_next);
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      extra_lane_reg        <= `RST_EXTRA_LANE;
      sync_word_content_reg <= `RST_SYNC_WORD;
      level_zero_reg        <= `RST_LEVEL_ZERO;
      level_one_reg         <= `RST_LEVEL_ONE;
      overrange_output_config_reg           <= `RST_OVERRANGE_OUTPUT_CONFIG;
      status_reg            <= 5'h00;
      mask_reg              <= 5'h00;
      flag_prev_reg         <= 4'h0;
      irq_reg               <= 1'b0;
    end
    else if (clk_en)
    begin
      extra_lane_reg        <= extra_lane_next;
      sync_word_content_reg <= sync_word_content_next;
      level_zero_reg        <= level_zero_next;
      level_one_reg         <= level_one_next;
      overrange_output_config_reg           <= overrange_output_config_next;
      status_reg            <= status_next;
      mask_reg              <= mask_next;
      flag_prev_reg         <= flags;
      irq_reg               <= irq_next;
    end
  end

  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // lane enables, serializer chain, lane patterns, sync word
  always_comb
  begin
    extra_mask   = {extra_lane_reg[7:1], 1'b0};
    powered      = ~&channel_power_down;
    ser_en_next  = 8'h00;
    pattern_next = '0;
    for (int n = 0; n < 8; n++)
    begin
      clk_en_next[n] = (mode_lane_mask[n] | extra_mask[n]) & powered;
      pattern_next[n] = link_test_pattern_select;
      if (extra_mask[n] && !mode_lane_mask[n] &&
          (link_test_pattern_select == `TP_CODE_ZERO ||
           link_test_pattern_select == `TP_CODE_FIVE))
      begin
        pattern_next[n] = `TP_CODE_RAMP;
      end
    end
    for (int n = 0; n < 8; n++)
    begin
      ser_en_next[n] = clk_en_next[n] &
                       (mode_lane_mask[n] | extra_lane_reg[`EXTRA_SER_BIT]);
      if (n > 0)
      begin
        ser_en_next[n] = ser_en_next[n] & (&(clk_en_next | ~(8'hff >> (8 - n))));
      end
    end
    fec_next = mode_is_64b66b &&
               sync_word_content_reg[`SYNC_HI:`SYNC_LO] == `SYNC_CODE_FEC;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clk_en_reg  <= 8'h00;
      ser_en_reg  <= 8'h00;
      pattern_reg <= '0;
      fec_reg     <= 1'b0;
    end
    else if (clk_en)
    begin
      clk_en_reg  <= clk_en_next;
      ser_en_reg  <= ser_en_next;
      pattern_reg <= pattern_next;
      fec_reg     <= fec_next;
    end
  end

  assign lane_clk_en    = clk_en_reg;
  assign lane_ser_en    = ser_en_reg;
  assign lane_pattern   = pattern_reg;
  assign sync_word_fec  = fec_reg;
  assign link_cmd_field = 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // over-range detection and pin gating
  always_comb
  begin
    // magnitude on a 256 full scale, so level/256 is the dBFS ratio
    level_a = {1'b0, chan_a_sample[6:0] ^ {7{chan_a_sample[7]}}, 1'b1};
    level_b = {1'b0, chan_b_sample[6:0] ^ {7{chan_b_sample[7]}}, 1'b1};
    hits[0] = level_a >= {1'b0, level_zero_reg};
    hits[1] = level_a >= {1'b0, level_one_reg};
    hits[2] = level_b >= {1'b0, level_zero_reg};
    hits[3] = level_b >= {1'b0, level_one_reg};
    pins_next = overrange_pin_enable ? flags : 4'h0;
  end

  for (genvar g = 0; g < 4; g++)
  begin : g_stretch
    overrange_stretch u_stretch (
      .sys_clk     (sys_clk),
      .nrst        (nrst),
      .clk_en      (clk_en),
      .hit         (hits[g]),
      .stretch_sel (overrange_pulse_stretch),
      .flag        (flags[g])
    );
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pins_reg <= 4'h0;
    end
    else if (clk_en)
    begin
      pins_reg <= pins_next;
    end
  end

  assign ovr_stream                = flags;
  assign chan_a_overrange_out_zero = pins_reg[0];
  assign chan_a_overrange_out_one  = pins_reg[1];
  assign chan_b_overrange_out_zero = pins_reg[2];
  assign chan_b_overrange_out_one  = pins_reg[3];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  a_lane_extra_clk: assert property (
    clk_en && extra_lane_reg[4] && powered |=> lane_clk_en[4])
    else $error("extra lane clock not enabled");

  a_ser_needs_bit: assert property (
    clk_en && !extra_lane_reg[0] && !mode_lane_mask[5] |=> !lane_ser_en[5])
    else $error("serializer on without serializer bit");

  a_ser_chain_low: assert property (
    lane_ser_en[3] |-> &lane_clk_en[2:0])
    else $error("serializer without lower lanes");

  a_extra_ramp: assert property (
    clk_en && extra_lane_reg[6] && !mode_lane_mask[6] &&
    link_test_pattern_select == 4'h5 |=> lane_pattern[6] == 4'h4)
    else $error("extra-only lane not ramping");

  a_sync_ignored: assert property (
    clk_en && !mode_is_64b66b |=> !sync_word_fec)
    else $error("sync select used in 8b/10b");

  a_thr_zero_hit: assert property (
    clk_en && level_a >= {1'b0, level_zero_reg} |=> ovr_stream[0])
    else $error("threshold zero missed");

  a_thr_one_hit: assert property (
    clk_en && level_b >= {1'b0, level_one_reg} |=> ovr_stream[3])
    else $error("threshold one missed");

  a_pins_held_low: assert property (
    clk_en && !overrange_pin_enable |=> pins_reg == 4'h0)
    else $error("pins not held low");

  a_stream_free_run: assert property (
    clk_en && hits[1] && !overrange_pin_enable |=> ovr_stream[1] && !pins_reg[1])
    else $error("stream bit gated by pin enable");

  a_stretch_min_len: assert property (
    clk_en && hits[0] && overrange_pulse_stretch == 3'h0 |=> ovr_stream[0] [*8])
    else $error("pulse shorter than eight cycles");

  a_bus_one_ack: assert property (
    clk_en && !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice");

  c_bus_write: cover property (clk_en && !avs_waitrequest && avs_req.write);
  c_pin_pulse: cover property (chan_a_overrange_out_zero ##1 !chan_a_overrange_out_zero);
  c_ramp_lane: cover property (lane_ser_en[2] && lane_pattern[2] == 4'h4);
  c_irq_raise: cover property (!irq ##1 irq);

endmodule

// ### pkg/ovr_defines.svh
/*
  Register indices, field positions, reset values and timing counts for the
  extra-lane and over-range register bank. Assumes inclusion by bare name.
*/
`ifndef OVR_DEFINES_SVH
`define OVR_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_EXTRA_LANE   10'h20b
`define IDX_SYNC_WORD    10'h20f
`define IDX_LEVEL_ZERO   10'h211
`define IDX_LEVEL_ONE    10'h212
`define IDX_OVERRANGE_OUTPUT_CONFIG      10'h213
`define IDX_IRQ_STATUS   10'h220
`define IDX_IRQ_MASK     10'h221
`define IDX_OVR_STATE    10'h222

// reset values
`define RST_EXTRA_LANE   8'h00
`define RST_SYNC_WORD    8'h00
`define RST_LEVEL_ZERO   8'hf2
`define RST_LEVEL_ONE    8'hab
`define RST_OVERRANGE_OUTPUT_CONFIG      8'h07

// field positions
`define EXTRA_SER_BIT    0
`define OVERRANGE_PIN_ENABLE_BIT       3
`define STRETCH_HI       2
`define STRETCH_LO       0
`define SYNC_HI          1
`define SYNC_LO          0

// field codes
`define SYNC_CODE_FEC    2'h2
`define TP_CODE_ZERO     4'h0
`define TP_CODE_FIVE     4'h5
`define TP_CODE_RAMP     4'h4

// pulse stretch: least length is base cycles shifted by the field
`define STRETCH_BASE     11'h008
`define STRETCH_W        11

`endif

// ### pkg/ovr_pkg.sv
/*
  Types shared by the register bank and its testbench.
  Assumes a single sys_clk domain.
*/
package ovr_pkg;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [11:0] address;
    logic [31:0] writedata;
  } avs_req_t;

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

  typedef logic [7:0][3:0] lane_pattern_t;

endpackage

// ### logic/overrange_stretch.sv
/*
  One over-range flag with pulse stretching.
  Assumes hit comes from logic on sys_clk; clk_en freezes the cell.
*/
`include "ovr_defines.svh"

module overrange_stretch (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic       hit,
  input  wire logic [2:0] stretch_sel,
  output logic            flag
);

  logic [`STRETCH_W-1:0] cnt_reg;
  logic [`STRETCH_W-1:0] cnt_next;
  logic                  flag_reg;
  logic                  flag_next;
  logic [`STRETCH_W-1:0] len;

  assign flag = flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // hold for 8 << field cycles after last hit
  always_comb
  begin
    len       = `STRETCH_BASE << stretch_sel;
    cnt_next  = cnt_reg;
    flag_next = flag_reg;
    if (hit)
    begin
      cnt_next  = len - `STRETCH_W'(1);
      flag_next = 1'b1;
    end
    else if (cnt_reg != '0)
    begin
      cnt_next  = cnt_reg - `STRETCH_W'(1);
      flag_next = 1'b1;
    end
    else
    begin
      flag_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg  <= '0;
      flag_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_reg  <= cnt_next;
      flag_reg <= flag_next;
    end
  end

endmodule

// ### tb/ovr_pin_watch.sv
/*
  Host-side watcher of the four over-range pins: length of each pin's last pulse.
  Assumes the pins are driven from logic on sys_clk.
*/
module ovr_pin_watch (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  pins,
  output logic [3:0][11:0] last_len
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0][11:0] run_len;

  ////////////////////////////////////////////////////////////////////////////////
  // count high cycles, keep the count when the pin falls
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      run_len  <= '0;
      last_len <= '0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (pins[i] === 1'b1)
          run_len[i] <= run_len[i] + 12'h001;
        else if (run_len[i] != 12'h000)
        begin
          last_len[i] <= run_len[i];
          run_len[i]  <= 12'h000;
        end
      end
    end
  end
endmodule

// ### tb/tb_link_b_lanes_and_overrange_cfg.sv
/*
  Self-checking bench for the extra-lane and over-range register bank.
  Assumes the design files and the pin watcher are compiled before it.
*/
`include "ovr_defines.svh"

module tb_link_b_lanes_and_overrange_cfg;
  import ovr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic             sys_clk;
  logic             nrst;
  logic             clk_en;
  avs_req_t         avs_req;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic             link_enable;
  logic [7:0]       mode_lane_mask;
  logic             mode_is_64b66b;
  logic [3:0]       link_test_pattern_select;
  logic [1:0]       channel_power_down;
  logic [7:0]       chan_a_sample;
  logic [7:0]       chan_b_sample;
  logic [7:0]       lane_clk_en;
  logic [7:0]       lane_ser_en;
  lane_pattern_t    lane_pattern;
  logic             sync_word_fec;
  logic [6:0]       link_cmd_field;
  logic [3:0]       ovr_stream;
  logic [3:0]       pins;
  logic             irq;
  logic [3:0][11:0] pulse_len;
  logic [31:0]      expq[$];
  logic [31:0]      seed;
  int               mismatches;
  int               comparisons;

  always #50 sys_clk = ~sys_clk;

  link_b_lanes_and_overrange_cfg uut (
    .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .link_enable(link_enable), .mode_lane_mask(mode_lane_mask),
    .mode_is_64b66b(mode_is_64b66b), .link_test_pattern_select(link_test_pattern_select),
    .channel_power_down(channel_power_down), .chan_a_sample(chan_a_sample),
    .chan_b_sample(chan_b_sample), .lane_clk_en(lane_clk_en), .lane_ser_en(lane_ser_en),
    .lane_pattern(lane_pattern), .sync_word_fec(sync_word_fec),
    .link_cmd_field(link_cmd_field), .ovr_stream(ovr_stream),
    .chan_a_overrange_out_zero(pins[0]), .chan_a_overrange_out_one(pins[1]),
    .chan_b_overrange_out_zero(pins[2]), .chan_b_overrange_out_one(pins[3]), .irq(irq)
  );

  ovr_pin_watch watch (.sys_clk(sys_clk), .nrst(nrst), .pins(pins), .last_len(pulse_len));

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] inr(input logic [11:0] len, input logic [11:0] lo);
    return {31'h0, (len >= lo) && (len <= lo + 12'h001)};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    avs_req <= '{read: !wr, write: wr, address: {idx, 2'b00}, writedata: d};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      mismatches++;
      test_done();
    end
    avs_req <= '0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, {24'h0, d});
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    expq.push_back({24'h0, e});
    bus(1'b0, idx, 32'h0);
  endtask

  task automatic pulse(input logic [7:0] a, input logic [7:0] b);
    chan_a_sample <= a;
    chan_b_sample <= b;
    cyc(1);
    chan_a_sample <= 8'h00;
    chan_b_sample <= 8'h00;
    cyc(2);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // read data watcher: oldest note against the answer
  always @(posedge sys_clk)
  begin
    if (avs_req.read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      if (expq.size() == 0)
        mismatches++;
      else
        check(avs_readdata, expq.pop_front());
    end
  end

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    clk_en = 1'b1;
    avs_req = '0;
    link_enable = 1'b0;
    mode_lane_mask = 8'h01;
    mode_is_64b66b = 1'b1;
    link_test_pattern_select = 4'h0;
    channel_power_down = 2'b00;
    chan_a_sample = 8'h00;
    chan_b_sample = 8'h00;
    seed = 32'h685a;
    cyc(6);
    nrst <= 1'b1;
    cyc(1);
    rd(`IDX_EXTRA_LANE, 8'h00);
    rd(`IDX_SYNC_WORD, 8'h00);
    rd(`IDX_LEVEL_ZERO, 8'hf2);
    rd(`IDX_LEVEL_ONE, 8'hab);
    rd(`IDX_OVERRANGE_OUTPUT_CONFIG, 8'h07);
    rd(10'h300, 8'h00);
    // extra lanes, host keeps link disabled and lower lanes on
    wr(`IDX_EXTRA_LANE, 8'h0e);
    cyc(3);
    check(32'(lane_clk_en), 32'h0f);
    check(32'(lane_ser_en), 32'h01);
    check(32'(lane_pattern[1]), 32'h4);
    check(32'(lane_pattern[0]), 32'h0);
    wr(`IDX_EXTRA_LANE, 8'h0f);
    link_test_pattern_select <= 4'h5;
    cyc(3);
    check(32'(lane_ser_en), 32'h0f);
    check(32'(lane_pattern[3]), 32'h4);
    link_test_pattern_select <= 4'h3;
    cyc(3);
    check(32'(lane_pattern[2]), 32'h3);
    wr(`IDX_EXTRA_LANE, 8'h13);
    cyc(3);
    check(32'(lane_clk_en), 32'h13);
    check(32'(lane_ser_en), 32'h03);
    channel_power_down <= 2'b01;
    cyc(3);
    check(32'(lane_clk_en), 32'h13);
    channel_power_down <= 2'b11;
    cyc(3);
    check(32'(lane_clk_en), 32'h00);
    channel_power_down <= 2'b00;
    // sync word content
    wr(`IDX_SYNC_WORD, 8'h02);
    cyc(3);
    check(32'(sync_word_fec), 32'h1);
    mode_is_64b66b <= 1'b0;
    cyc(3);
    check(32'(sync_word_fec), 32'h0);
    mode_is_64b66b <= 1'b1;
    wr(`IDX_SYNC_WORD, 8'h03);
    cyc(3);
    check(32'(sync_word_fec), 32'h0);
    rd(`IDX_SYNC_WORD, 8'h03);
    check(32'(link_cmd_field), 32'h0);
    // over-range detection and pins
    wr(`IDX_OVERRANGE_OUTPUT_CONFIG, 8'h08);
    pulse(8'h7f, 8'ha0);
    check(32'(pins), 32'hb);
    cyc(20);
    check(inr(pulse_len[0], 12'd8), 32'h1);
    check(inr(pulse_len[1], 12'd8), 32'h1);
    check(32'(pulse_len[2]), 32'h0);
    check(inr(pulse_len[3], 12'd8), 32'h1);
    wr(`IDX_OVERRANGE_OUTPUT_CONFIG, 8'h0a);
    pulse(8'h60, 8'h00);
    check(32'(ovr_stream), 32'h2);
    cyc(40);
    check(inr(pulse_len[1], 12'd32), 32'h1);
    wr(`IDX_OVERRANGE_OUTPUT_CONFIG, 8'h00);
    pulse(8'h7f, 8'h00);
    check(32'(ovr_stream), 32'h3);
    check(32'(pins), 32'h0);
    cyc(20);
    // frozen clock enable: a sample seen only while frozen leaves no trace
    clk_en <= 1'b0;
    pulse(8'h7f, 8'h7f);
    clk_en <= 1'b1;
    cyc(2);
    check(32'(ovr_stream), 32'h0);
    // interrupts
    rd(`IDX_IRQ_STATUS, 8'h0b);
    check(32'(irq), 32'h0);
    wr(`IDX_IRQ_MASK, 8'h01);
    cyc(2);
    check(32'(irq), 32'h1);
    wr(`IDX_IRQ_STATUS, 8'h01);
    cyc(2);
    check(32'(irq), 32'h0);
    link_enable <= 1'b1;
    wr(`IDX_EXTRA_LANE, 8'h00);
    link_enable <= 1'b0;
    rd(`IDX_IRQ_STATUS, 8'h1a);
    wr(`IDX_IRQ_MASK, 8'h10);
    cyc(2);
    check(32'(irq), 32'h1);
    wr(`IDX_IRQ_STATUS, 8'h1f);
    cyc(2);
    check(32'(irq), 32'h0);
    // random threshold values
    repeat (4)
    begin
      seed = lfsr(seed);
      wr(`IDX_LEVEL_ONE, seed[7:0]);
      rd(`IDX_LEVEL_ONE, seed[7:0]);
    end
    cyc(2);
    test_done();
  end
endmodule
